/* File: rtl/pfw_ctrl.sv */
// Power controller fault flags, interrupt mask, fast start-up and low-power control.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps

// Function
// R1 - A detected main RC clock failure sets a sticky event flag that a status read clears.
// R2 - A live status bit mirrors the current main RC clock failure detection.
// R3 - A status bit shows whether the failure detector fault output is active.
// R4 - The slow crystal error is 0 when in tolerance or unmonitored, else 1 and held.
// R5 - The mask view shows crystal, lock, master clock and programmable clock enables.
// R6 - The mask view also shows oscillator select, RC stable, failure event, crystal error.
// R7 - Writes to the start-up mode and polarity registers are ignored while locked.
// R8 - Each of sixteen wake inputs may request a fast restart only when enabled.
// R9 - An enabled wake input requests a restart only at the level of its polarity bit.
// R10 - The timer alarm requests a fast restart only when its enable is set.
// R11 - The calendar alarm requests a fast restart only when its enable is set.
// R12 - The low-power bit chooses sleep on any wait instruction or wait mode on wait-for-event.
// R13 - The flash field selects standby, deep power-down or idle on wait mode entry.
// R14 - The write-only fault clear register has one command bit at bit 0.
// R15 - Writing the clear command deactivates the fault output and its status bit.
// R16 - The interrupt line is high while any flagged source is enabled in the mask.
module pfw_ctrl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        main_xtal_stable,
  input  wire logic        pll_locked,
  input  wire logic        master_clk_ready,
  input  wire logic [2:0]  prog_clk_ready,
  input  wire logic        osc_select_done,
  input  wire logic        main_rc_stable,
  input  wire logic        slow_clk_ext_sel,
  input  wire logic        clk_fail_live,
  input  wire logic        slow_xtal_mon_en,
  input  wire logic        slow_xtal_bad,
  input  wire logic [15:0] wake_in,
  input  wire logic        timer_alarm,
  input  wire logic        calendar_alarm,
  input  wire logic        wait_interrupt_instr,
  input  wire logic        wait_event_instr,
  output logic             fault_out,
  output logic             fast_restart,
  output logic             sleep_req,
  output logic             wait_req,
  output logic      [1:0]  flash_wait_state_mode,
  output logic             irq
);

  pfw_pkg::pfw_state_type st_r;
  pfw_pkg::pfw_state_type st_nxt;

  // Bus phase signals.
  logic        accept;
  logic        rd_take;
  logic        wr_now;
  logic [31:0] rd_word;

  // Register decode of the address phase and of the data phase.
  logic        rd_status;
  logic        rd_mask;
  logic        rd_mode;
  logic        rd_pol;
  logic        rd_lock;
  logic        rd_irqs;
  logic        wr_ien;
  logic        wr_idis;
  logic        wr_mode;
  logic        wr_pol;
  logic        wr_fclr;
  logic        wr_lock;
  logic        wr_irqs;

  // Event, flag and request signals.
  logic [31:0] status;
  logic [31:0] wake_hit;
  logic [31:0] rise;
  logic [31:0] w1c;
  logic [31:0] flag_nxt;
  logic [31:0] mask_bits;
  logic        key_ok;
  logic        cfg_open;
  logic        clr_cmd;
  logic        cf_rise;
  logic        wake_any;
  logic        tmr_hit;
  logic        cal_hit;
  logic        restart_nxt;
  logic        low_pwr;
  logic        sleep_nxt;
  logic        wait_nxt;
  logic        irq_any;
  logic        xerr_nxt;
  logic [1:0]  flash_nxt;

  // Compares a bus address with a register address.
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  // Keeps only the implemented bits of a written word.
  function automatic logic [31:0] keep(input logic [31:0] d, input logic [31:0] valid);
    keep = d & valid;
  endfunction

  // Zero wait states and an always OKAY response.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign accept    = hsel & htrans[1] & hready;
  assign rd_take   = accept & ~hwrite;
  assign wr_now    = st_r.wr_pend;

  // Reads are decoded at the address phase.
  assign rd_status = rd_take & hit(haddr, pfw_pkg::ADDR_STATUS);
  assign rd_mask   = rd_take & hit(haddr, pfw_pkg::ADDR_IMR);
  assign rd_mode   = rd_take & hit(haddr, pfw_pkg::ADDR_FSMR);
  assign rd_pol    = rd_take & hit(haddr, pfw_pkg::ADDR_FSPR);
  assign rd_lock   = rd_take & hit(haddr, pfw_pkg::ADDR_WPMR);
  assign rd_irqs   = rd_take & hit(haddr, pfw_pkg::ADDR_IRQ_STAT);

  // Writes are decoded at the data phase against the held address.
  assign wr_ien  = wr_now & hit(st_r.wr_addr, pfw_pkg::ADDR_IER);
  assign wr_idis = wr_now & hit(st_r.wr_addr, pfw_pkg::ADDR_IDR);
  assign wr_mode = wr_now & hit(st_r.wr_addr, pfw_pkg::ADDR_FSMR);
  assign wr_pol  = wr_now & hit(st_r.wr_addr, pfw_pkg::ADDR_FSPR);
  assign wr_fclr = wr_now & hit(st_r.wr_addr, pfw_pkg::ADDR_FOCR);
  assign wr_lock = wr_now & hit(st_r.wr_addr, pfw_pkg::ADDR_WPMR);
  assign wr_irqs = wr_now & hit(st_r.wr_addr, pfw_pkg::ADDR_IRQ_STAT);

  // Write qualifiers.
  assign key_ok    = (hwdata[31:8] == pfw_pkg::WP_KEY);
  assign cfg_open  = ~st_r.write_lock; // R7
  assign mask_bits = keep(hwdata, pfw_pkg::IMR_VALID);
  assign clr_cmd   = wr_fclr & hwdata[pfw_pkg::B_FAULT_CLR]; // R14
  assign cf_rise   = clk_fail_live & ~st_r.cf_prev;

  // Live status word seen by software.
  always_comb begin
    status                         = 32'h0000_0000;
    status[pfw_pkg::B_XTAL]        = main_xtal_stable;
    status[pfw_pkg::B_PLL]         = pll_locked;
    status[pfw_pkg::B_MCK]         = master_clk_ready;
    status[pfw_pkg::B_SLOW_SEL]    = slow_clk_ext_sel;
    status[pfw_pkg::B_PCK0 +: 3]   = prog_clk_ready;
    status[pfw_pkg::B_OSCSEL]      = osc_select_done;
    status[pfw_pkg::B_RC]          = main_rc_stable;
    status[pfw_pkg::B_CF_EVENT]    = st_r.cf_event; // R1
    status[pfw_pkg::B_CF_LIVE]     = clk_fail_live; // R2
    status[pfw_pkg::B_FAULT]       = st_r.fault_out; // R3
    status[pfw_pkg::B_XERR]        = st_r.xerr; // R4
  end

  // Wake inputs match their polarity level.
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_wake
      if (gi < pfw_pkg::NUM_WAKE) begin : g_in
        assign wake_hit[gi] = st_r.fsmr[gi] & ~(wake_in[gi] ^ st_r.fspr[gi]); // R8 R9
      end else begin : g_zero
        assign wake_hit[gi] = 1'b0;
      end
    end
  endgenerate

  // Fast restart sources.
  assign wake_any    = |wake_hit; // R8 R9
  assign tmr_hit     = st_r.fsmr[pfw_pkg::B_TMR_WAKE] & timer_alarm; // R10
  assign cal_hit     = st_r.fsmr[pfw_pkg::B_CAL_WAKE] & calendar_alarm; // R11
  assign restart_nxt = wake_any | tmr_hit | cal_hit;

  // Slow crystal error holds while monitoring stays enabled.
  assign xerr_nxt = slow_xtal_mon_en & (st_r.xerr | slow_xtal_bad); // R4

  // Flash setting used on wait mode entry.
  assign flash_nxt = st_r.fsmr[pfw_pkg::B_FLASH_MODE +: 2]; // R13

  // Sticky interrupt flags, write one to clear, a new event wins.
  assign rise = status & ~st_r.prev_status & pfw_pkg::IMR_VALID;
  assign w1c  = wr_irqs ? hwdata : 32'h0000_0000;
  genvar gj;
  generate
    for (gj = 0; gj < 32; gj++) begin : g_flag
      if (pfw_pkg::IMR_VALID[gj]) begin : g_used
        assign flag_nxt[gj] = (st_r.irq_stat[gj] & ~w1c[gj]) | rise[gj];
      end else begin : g_rsvd
        assign flag_nxt[gj] = 1'b0;
      end
    end
  endgenerate
  assign irq_any = |(st_r.irq_stat & st_r.imr); // R16

  // Low-power entry on wait instructions.
  assign low_pwr = st_r.fsmr[pfw_pkg::B_LOW_POWER];
  always_comb begin
    sleep_nxt = 1'b0;
    wait_nxt  = 1'b0;
    if (!low_pwr) begin
      sleep_nxt = wait_interrupt_instr | wait_event_instr; // R12
    end else begin
      wait_nxt  = wait_event_instr; // R12
      sleep_nxt = wait_interrupt_instr & ~wait_event_instr;
    end
  end

  // Read data selected at the address phase.
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_status) begin
      rd_word = status;
    end
    if (rd_mask) begin
      rd_word = st_r.imr; // R5 R6
    end
    if (rd_mode) begin
      rd_word = st_r.fsmr;
    end
    if (rd_pol) begin
      rd_word = st_r.fspr;
    end
    if (rd_lock) begin
      rd_word = {31'h0000_0000, st_r.write_lock};
    end
    if (rd_irqs) begin
      rd_word = st_r.irq_stat;
    end
  end

  always_comb begin
    st_nxt = st_r;

    // Bus phase tracking.
    st_nxt.wr_pend = accept & hwrite;
    if (accept) begin
      st_nxt.wr_addr = haddr;
    end

    // Read data is latched at the address phase and shown in the data phase.
    if (rd_take) begin
      st_nxt.hrdata = rd_word;
    end

    // Interrupt mask set and clear.
    if (wr_ien) begin
      st_nxt.imr = st_r.imr | mask_bits; // R5 R6
    end
    if (wr_idis) begin
      st_nxt.imr = st_r.imr & ~mask_bits;
    end

    // Protected start-up configuration.
    if (wr_mode && cfg_open) begin
      st_nxt.fsmr = keep(hwdata, pfw_pkg::FSMR_VALID); // R7
    end
    if (wr_pol && cfg_open) begin
      st_nxt.fspr = keep(hwdata, pfw_pkg::FSPR_VALID); // R7
    end

    // Write protection key and enable.
    if (wr_lock && key_ok) begin
      st_nxt.write_lock = hwdata[pfw_pkg::B_WRITE_LOCK];
    end

    // Clock failure event: a status read clears it, a new failure wins.
    st_nxt.cf_prev = clk_fail_live;
    if (rd_status) begin
      st_nxt.cf_event = 1'b0; // R1
    end
    if (cf_rise) begin
      st_nxt.cf_event = 1'b1; // R1
    end

    // Fault output: cleared by command, a new failure wins.
    if (clr_cmd) begin
      st_nxt.fault_out = 1'b0; // R14 R15
    end
    if (cf_rise) begin
      st_nxt.fault_out = 1'b1; // R3
    end

    // Slow crystal error.
    st_nxt.xerr = xerr_nxt; // R4

    // Interrupt flags and line.
    st_nxt.prev_status = status;
    st_nxt.irq_stat    = flag_nxt;
    st_nxt.irq         = irq_any; // R16

    // Requests toward the power sequencer.
    st_nxt.fast_restart = restart_nxt; // R8 R9 R10 R11
    st_nxt.sleep_req    = sleep_nxt; // R12
    st_nxt.wait_req     = wait_nxt; // R12
    st_nxt.flash_mode   = flash_nxt; // R13
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Bus tracking.
      st_r.wr_pend      <= 1'b0;
      st_r.wr_addr      <= 32'h0000_0000;
      st_r.hrdata       <= 32'h0000_0000;

      // Configuration and protection.
      st_r.fsmr         <= pfw_pkg::RST_FSMR;
      st_r.fspr         <= pfw_pkg::RST_FSPR;
      st_r.imr          <= pfw_pkg::RST_IMR;
      st_r.write_lock   <= 1'b0;

      // Flags and requests.
      st_r.cf_event     <= 1'b0;
      st_r.cf_prev      <= 1'b0;
      st_r.fault_out    <= 1'b0;
      st_r.xerr         <= 1'b0;
      st_r.irq_stat     <= 32'h0000_0000;
      st_r.prev_status  <= 32'h0000_0000;
      st_r.fast_restart <= 1'b0;
      st_r.sleep_req    <= 1'b0;
      st_r.wait_req     <= 1'b0;
      st_r.flash_mode   <= 2'h0;
      st_r.irq          <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bus outputs.
  assign hrdata                = st_r.hrdata;

  // Power sequencer requests and interrupt.
  assign fault_out             = st_r.fault_out;
  assign fast_restart          = st_r.fast_restart;
  assign sleep_req             = st_r.sleep_req;
  assign wait_req              = st_r.wait_req;
  assign flash_wait_state_mode = st_r.flash_mode;
  assign irq                   = st_r.irq;

endmodule

/* File: common/pfw_pkg.sv */
// Package holding register map, field positions, reset values and state type.
package pfw_pkg;

  localparam logic [31:0] ADDR_IER      = 32'h400e0460;
  localparam logic [31:0] ADDR_IDR      = 32'h400e0464;
  localparam logic [31:0] ADDR_STATUS   = 32'h400e0468;
  localparam logic [31:0] ADDR_IMR      = 32'h400e046c;
  localparam logic [31:0] ADDR_FSMR     = 32'h400e0470;
  localparam logic [31:0] ADDR_FSPR     = 32'h400e0474;
  localparam logic [31:0] ADDR_FOCR     = 32'h400e0478;
  localparam logic [31:0] ADDR_WPMR     = 32'h400e04e4;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h400e04f0;

  localparam int B_XTAL      = 0;
  localparam int B_PLL       = 1;
  localparam int B_MCK       = 3;
  localparam int B_SLOW_SEL  = 7;
  localparam int B_PCK0      = 8;
  localparam int B_OSCSEL    = 16;
  localparam int B_RC        = 17;
  localparam int B_CF_EVENT  = 18;
  localparam int B_CF_LIVE   = 19;
  localparam int B_FAULT     = 20;
  localparam int B_XERR      = 21;

  localparam int B_TMR_WAKE  = 16;
  localparam int B_CAL_WAKE  = 17;
  localparam int B_LOW_POWER  = 20;
  localparam int B_FLASH_MODE = 21;
  localparam int B_FAULT_CLR  = 0;
  localparam int B_WRITE_LOCK = 0;
  localparam int NUM_WAKE    = 16;

  localparam logic [31:0] IMR_VALID  = 32'h0027_070b;
  localparam logic [31:0] FSMR_VALID = 32'h0073_ffff;
  localparam logic [31:0] FSPR_VALID = 32'h0000_ffff;
  localparam logic [23:0] WP_KEY     = 24'h504d43;

  localparam logic [1:0] FLASH_STANDBY   = 2'h0;
  localparam logic [1:0] FLASH_DEEP_DOWN = 2'h1;
  localparam logic [1:0] FLASH_IDLE      = 2'h2;

  localparam logic [31:0] RST_FSMR = 32'h0000_0000;
  localparam logic [31:0] RST_FSPR = 32'h0000_0000;
  localparam logic [31:0] RST_IMR  = 32'h0000_0000;

  typedef struct packed {
    logic        wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] fsmr;
    logic [31:0] fspr;
    logic [31:0] imr;
    logic        write_lock;
    logic        cf_event;
    logic        cf_prev;
    logic        fault_out;
    logic        xerr;
    logic [31:0] irq_stat;
    logic [31:0] prev_status;
    logic [31:0] hrdata;
    logic        fast_restart;
    logic        sleep_req;
    logic        wait_req;
    logic [1:0]  flash_mode;
    logic        irq;
  } pfw_state_type;

endpackage

/* File: dv/pfw_checker.sv */
// Port checker of the fault, wake-up and low-power block.
`timescale 1ns/100ps
module pfw_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        clk_fail_live,
  input wire logic        slow_xtal_mon_en,
  input wire logic        wait_interrupt_instr,
  input wire logic        wait_event_instr,
  input wire logic        fault_out,
  input wire logic        sleep_req,
  input wire logic        wait_req
);
  logic rd;
  logic rs;
  assign rd = hsel && htrans[1] && hready && !hwrite;
  assign rs = rd && haddr == pfw_pkg::ADDR_STATUS;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_fault_set: assert property ($rose(clk_fail_live) |=> fault_out)
    else $error("fault not raised");
  a_fault_cause: assert property (
    $rose(fault_out) |-> $past(clk_fail_live) && !$past(clk_fail_live, 2))
    else $error("fault without cause");
  a_wint_sleep: assert property (wait_interrupt_instr |=> sleep_req)
    else $error("no sleep");
  a_wevt_choice: assert property (
    wait_event_instr && !wait_interrupt_instr |=> sleep_req != wait_req)
    else $error("bad wait choice");
  a_mask_rsvd: assert property (
    rd && haddr == pfw_pkg::ADDR_IMR |=> (hrdata & ~pfw_pkg::IMR_VALID) == 32'h0)
    else $error("mask reserved set");
  a_xerr_off: assert property (
    rs && !slow_xtal_mon_en && !$past(slow_xtal_mon_en) |=> !hrdata[21])
    else $error("xtal error unmonitored");
  a_live_bit: assert property (
    rs && $stable(clk_fail_live) |=> hrdata[19] == $past(clk_fail_live))
    else $error("live bit wrong");
  a_event_clr: assert property (
    rs && $stable(clk_fail_live) ##1 $stable(clk_fail_live)[*2] ##1 rs |=> !hrdata[18])
    else $error("event not cleared");
  c_wait: cover property (wait_req);
  c_fault: cover property ($rose(fault_out));
  c_xerr: cover property (rs ##1 hrdata[21]);
endmodule
bind pfw_ctrl pfw_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .clk_fail_live, .slow_xtal_mon_en, .wait_interrupt_instr, .wait_event_instr,
  .fault_out, .sleep_req, .wait_req);

/* File: dv/pfw_ctrl_tb_top.sv */
// Self-checking bench of the fault, wake-up and low-power block.
`timescale 1ns/100ps
module pfw_ctrl_tb_top;
  typedef struct packed {
    logic [31:0] m;
    logic [15:0] p;
    logic [15:0] w;
    logic [2:0]  tcr;
  } pfw_row_type;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fault_out, fast_restart, irq;
  logic        sleep_req, wait_req, live, mon, bad, wint, wevt;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [15:0] wake;
  logic [8:0]  lv;
  logic [2:0]  hsize, tc;
  logic [1:0]  htrans, flm;
  int          errors, n_checks, i;
  pfw_row_type rows [6] = '{'{32'h1, 16'h1, 16'h1, 3'h1}, '{32'h0, 16'h1, 16'h1, 3'h6},
    '{32'h8000, 16'h0, 16'h0, 3'h1}, '{32'h8000, 16'h0, 16'h8000, 3'h0},
    '{32'h10000, 16'h0, 16'h0, 3'h5}, '{32'h20000, 16'h0, 16'h0, 3'h4}};
  pfw_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .main_xtal_stable(lv[0]),
    .pll_locked(lv[1]), .master_clk_ready(lv[2]), .prog_clk_ready(lv[5:3]),
    .osc_select_done(lv[6]), .main_rc_stable(lv[7]), .slow_clk_ext_sel(lv[8]),
    .clk_fail_live(live), .slow_xtal_mon_en(mon), .slow_xtal_bad(bad), .wake_in(wake),
    .timer_alarm(tc[2]), .calendar_alarm(tc[1]), .wait_interrupt_instr(wint),
    .wait_event_instr(wevt), .fault_out, .fast_restart, .sleep_req, .wait_req,
    .flash_wait_state_mode(flm), .irq);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic ins(input logic a, b, s, w);
    @(posedge hclk);
    wint <= a;
    wevt <= b;
    @(posedge hclk);
    wint <= 1'b0;
    wevt <= 1'b0;
    #1;
    chk("sleep", sleep_req, s);
    chk("wait", wait_req, w);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {hsel, hwrite, live, mon, bad, wint, wevt, haddr, hwdata, wake, lv, tc, htrans} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, pfw_pkg::ADDR_FSMR, 32'h0);
    chk("fsmr", q, pfw_pkg::RST_FSMR);
    bus(1'b1, pfw_pkg::ADDR_IER, 32'hffffffff);
    bus(1'b1, pfw_pkg::ADDR_IMR, 32'h0);
    bus(1'b0, pfw_pkg::ADDR_IMR, 32'h0);
    chk("imr", q, pfw_pkg::IMR_VALID);
    for (i = 0; i < 6; i++) begin
      wake <= rows[i].w;
      tc <= rows[i].tcr;
      bus(1'b1, pfw_pkg::ADDR_FSMR, rows[i].m);
      bus(1'b1, pfw_pkg::ADDR_FSPR, {16'h0, rows[i].p});
      cyc(2);
      chk("restart", fast_restart, rows[i].tcr[0]);
    end
    for (i = 0; i < 3; i++) begin
      bus(1'b1, pfw_pkg::ADDR_FSMR, 32'(i) << 21);
      cyc(2);
      chk("flash", flm, 32'(i));
    end
    ins(1'b1, 1'b0, 1'b1, 1'b0);
    ins(1'b0, 1'b1, 1'b1, 1'b0);
    bus(1'b1, pfw_pkg::ADDR_FSMR, 32'h100000);
    ins(1'b0, 1'b1, 1'b0, 1'b1);
    ins(1'b1, 1'b0, 1'b1, 1'b0);
    bus(1'b1, pfw_pkg::ADDR_WPMR, {pfw_pkg::WP_KEY, 8'h01});
    bus(1'b1, pfw_pkg::ADDR_FSMR, 32'hffff);
    bus(1'b0, pfw_pkg::ADDR_FSMR, 32'h0);
    chk("locked", q, 32'h100000);
    bus(1'b1, pfw_pkg::ADDR_FSPR, 32'hffff);
    bus(1'b0, pfw_pkg::ADDR_FSPR, 32'h0);
    chk("locked_pol", q, 32'h0);
    bus(1'b1, pfw_pkg::ADDR_IRQ_STAT, 32'hffffffff);
    cyc(2);
    chk("irq", irq, 1'b0);
    live <= 1'b1;
    cyc(3);
    chk("fault", fault_out, 1'b1);
    chk("irq", irq, 1'b1);
    bus(1'b0, pfw_pkg::ADDR_STATUS, 32'h0);
    chk("st", q & 32'h1c0000, 32'h1c0000);
    bus(1'b0, pfw_pkg::ADDR_STATUS, 32'h0);
    chk("st", q & 32'h40000, 32'h0);
    bus(1'b1, pfw_pkg::ADDR_FOCR, 32'hfffffffe);
    cyc(2);
    chk("fault_kept", fault_out, 1'b1);
    bus(1'b1, pfw_pkg::ADDR_FOCR, 32'h1);
    cyc(2);
    chk("fault", fault_out, 1'b0);
    bus(1'b1, pfw_pkg::ADDR_IRQ_STAT, 32'hffffffff);
    bus(1'b1, pfw_pkg::ADDR_IDR, 32'hffffffff);
    live <= 1'b0;
    lv <= 9'h1ff;
    mon <= 1'b1;
    bad <= 1'b1;
    cyc(3);
    chk("irq", irq, 1'b0);
    bus(1'b1, pfw_pkg::ADDR_IER, 32'h1);
    bad <= 1'b0;
    cyc(2);
    chk("irq", irq, 1'b1);
    bus(1'b0, pfw_pkg::ADDR_STATUS, 32'h0);
    chk("xerr", q[21], 1'b1);
    mon <= 1'b0;
    bus(1'b0, pfw_pkg::ADDR_STATUS, 32'h0);
    chk("xerr", q[21], 1'b0);
    live <= 1'b1;
    cyc(3);
    hresetn <= 1'b0;
    live <= 1'b0;
    cyc(2);
    chk("rst_fault", fault_out, 1'b0);
    chk("rst_irq", irq, 1'b0);
    chk("hreadyout", hreadyout, 1'b1);
    chk("hresp", hresp, 1'b0);
    hresetn <= 1'b1;
    bus(1'b0, pfw_pkg::ADDR_FSMR, 32'h0);
    chk("rst_fsmr", q, pfw_pkg::RST_FSMR);
    bus(1'b1, pfw_pkg::ADDR_FSMR, 32'h3);
    bus(1'b0, pfw_pkg::ADDR_FSMR, 32'h0);
    chk("unlocked", q, 32'h3);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    complete_run();
  end
endmodule
